//--- common/serial_port_pkg.sv
package serial_port_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [4:0] ADDR_FRAME_MODE = 5'h00;
  localparam logic [4:0] ADDR_CONTROL = 5'h04;
  localparam logic [4:0] ADDR_RATE_DIV = 5'h08;
  localparam logic [4:0] ADDR_TX_HOLDING = 5'h0c;
  localparam logic [4:0] ADDR_RX_HOLDING = 5'h10;
  localparam logic [4:0] ADDR_FLAGS = 5'h14;
  localparam logic [4:0] ADDR_EXT_MODE = 5'h18;
  localparam logic [4:0] ADDR_PORT = 5'h1c;

  // ==========================================================
  // field positions
  localparam int FM_SYNC_MODE = 7;
  localparam int FM_CHAR7 = 6;
  localparam int FM_PARITY_EN = 5;
  localparam int FM_PARITY_ODD = 4;
  localparam int FM_TWO_STOP = 3;
  localparam int CT_TX_EMPTY_IRQ_ON = 7;
  localparam int CT_RX_IRQ_ON = 6;
  localparam int CT_TX_ON = 5;
  localparam int CT_RX_ON = 4;
  localparam int CT_TX_DONE_IRQ_ON = 2;
  localparam int CT_CLK_SRC_HI = 1;
  localparam int CT_CLK_SRC_LO = 0;
  localparam int FL_TX_EMPTY = 7;
  localparam int FL_RX_FULL = 6;
  localparam int FL_OVERRUN = 5;
  localparam int FL_FRAMING = 4;
  localparam int FL_PARITY = 3;
  localparam int FL_TX_DONE = 2;
  localparam int EM_HALF_SAMPLE = 3;
  localparam int PT_PORT_DIR = 1;
  localparam int PT_PORT_OUT = 0;

  // ==========================================================
  // reset values and sampling counts
  localparam logic [7:0] RST_FRAME_MODE = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_RATE_DIV = 8'h00;
  localparam logic [7:0] RST_EXT_MODE = 8'h00;
  localparam logic [1:0] RST_PORT = 2'h0;
  localparam logic [3:0] SUB_LAST_X16 = 4'hf;
  localparam logic [3:0] SUB_LAST_X8 = 4'h7;

  // ==========================================================
  // types
  typedef struct packed {
    logic sync_mode_select;
    logic char7;
    logic parity_en;
    logic parity_odd_select;
    logic two_stop;
  } frame_cfg_type;

  typedef enum logic [1:0] {
    TX_OFF = 2'b00,
    TX_PREAMBLE = 2'b01,
    TX_IDLE = 2'b10,
    TX_SEND = 2'b11
  } tx_state_type;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10
  } rx_state_type;

endpackage : serial_port_pkg

//--- design/async_serial_port_core.sv
// Behaviour
// - async, internal clock: clock pin left free
// - async internal, clk_src_lo: bit-rate clock out
// - async clk_src_hi: external clock, sixteen per bit
// - half_sample_select: external clock eight per bit
// - sync mode: pin output internal, input external
// - tx_on clear sets empty; rx_on keeps flags
// - empty low: load shift, set empty, start
// - stop time, word waiting: continue without gap
// - stop time, none waiting: done flag, mark
// - holding write clears tx_empty_flag while tx_on set
// - after tx_on, one idle frame first
// - detect start, synchronise, shift, then check
// - parity checked against odd or even select
// - first stop bit must be one
// - frame while full: overrun, data dropped
// - parity fault flagged, data still stored
// - framing fault flagged, data still stored
// - good frame stored, rx_full_flag set
// - errors keep full flag, block reception
// - holding read after overrun clears full
module async_serial_port_core #(
  parameter int DIV_W = 8
) (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic [4:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [7:0] RD_DATA,
  input wire logic RXD,
  output logic TXD,
  output logic TXD_OE,
  input wire logic SCK_IN,
  output logic SCK_OUT,
  output logic SCK_OE,
  output logic TX_EMPTY_IRQ,
  output logic TX_DONE_IRQ,
  output logic RX_FULL_IRQ,
  output logic RX_FAULT_IRQ
);

  initial begin
    if (DIV_W < 1 || DIV_W > 8) begin
      $error("DIV_W must lie in 1..8");
    end
  end

  // ==========================================================
  // helpers
  function automatic logic [3:0] data_bits(input serial_port_pkg::frame_cfg_type c);
    data_bits = c.char7 ? 4'h7 : 4'h8;
  endfunction : data_bits

  // index of the first stop bit counted from the start bit
  function automatic logic [3:0] stop_index(input serial_port_pkg::frame_cfg_type c);
    stop_index = 4'h1 + data_bits(c) + {3'h0, c.parity_en};
  endfunction : stop_index

  function automatic logic [3:0] frame_len(input serial_port_pkg::frame_cfg_type c);
    frame_len = stop_index(c) + 4'h1 + {3'h0, c.two_stop};
  endfunction : frame_len

  function automatic logic [11:0] build_frame(input serial_port_pkg::frame_cfg_type c, input logic [7:0] d);
    logic [7:0] m;
    logic p;
    m = c.char7 ? {1'b0, d[6:0]} : d;
    p = (^m) ^ c.parity_odd_select;
    build_frame = 12'hfff;
    build_frame[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(data_bits(c))) begin
        build_frame[1 + i] = m[i];
      end
    end
    if (c.parity_en) begin
      build_frame[1 + int'(data_bits(c))] = p;
    end
  endfunction : build_frame

  // ==========================================================
  // software registers
  logic [7:0] frame_mode_reg_ff;
  logic [7:0] control_reg_ff;
  logic [DIV_W-1:0] rate_div_ff;
  logic [7:0] ext_mode_reg_ff;
  logic [1:0] port_reg_ff;
  logic [7:0] tx_holding_reg_ff;
  logic [7:0] rx_holding_reg_ff;
  logic tx_empty_flag_ff;
  logic tx_done_flag_ff;
  logic rx_full_flag_ff;
  logic overrun_flag_ff;
  logic framing_fault_flag_ff;
  logic parity_fault_flag_ff;
  serial_port_pkg::frame_cfg_type cfg;
  logic tx_on;
  logic rx_on;
  logic wr_ctl;
  logic wr_tx;
  logic wr_flags;
  logic rd_rx;

  assign cfg = frame_mode_reg_ff[7:3];
  assign tx_on = control_reg_ff[serial_port_pkg::CT_TX_ON];
  assign rx_on = control_reg_ff[serial_port_pkg::CT_RX_ON];
  assign wr_ctl = WR_STB && (ADDR == serial_port_pkg::ADDR_CONTROL);
  assign wr_tx = WR_STB && (ADDR == serial_port_pkg::ADDR_TX_HOLDING);
  assign wr_flags = WR_STB && (ADDR == serial_port_pkg::ADDR_FLAGS);
  assign rd_rx = RD_STB && (ADDR == serial_port_pkg::ADDR_RX_HOLDING);

  // plain configuration writes
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      frame_mode_reg_ff <= serial_port_pkg::RST_FRAME_MODE;
      control_reg_ff <= serial_port_pkg::RST_CONTROL;
      rate_div_ff <= serial_port_pkg::RST_RATE_DIV[DIV_W-1:0];
      ext_mode_reg_ff <= serial_port_pkg::RST_EXT_MODE;
      port_reg_ff <= serial_port_pkg::RST_PORT;
    end else if (WR_STB) begin
      case (ADDR)
        serial_port_pkg::ADDR_FRAME_MODE: frame_mode_reg_ff <= {WR_DATA[7:3], 3'h0};
        serial_port_pkg::ADDR_CONTROL: control_reg_ff <= WR_DATA;
        serial_port_pkg::ADDR_RATE_DIV: rate_div_ff <= WR_DATA[DIV_W-1:0];
        serial_port_pkg::ADDR_EXT_MODE: ext_mode_reg_ff <= {4'h0, WR_DATA[3], 3'h0};
        serial_port_pkg::ADDR_PORT: port_reg_ff <= WR_DATA[1:0];
        default: ;
      endcase
    end
  end

  // transmit holding register
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      tx_holding_reg_ff <= 8'h00;
    end else if (wr_tx) begin
      tx_holding_reg_ff <= WR_DATA;
    end
  end

  // read data, valid the cycle after the strobe
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      RD_DATA <= 8'h00;
    end else if (RD_STB) begin
      case (ADDR)
        serial_port_pkg::ADDR_FRAME_MODE: RD_DATA <= frame_mode_reg_ff;
        serial_port_pkg::ADDR_CONTROL: RD_DATA <= control_reg_ff;
        serial_port_pkg::ADDR_RATE_DIV: RD_DATA <= 8'(rate_div_ff);
        serial_port_pkg::ADDR_TX_HOLDING: RD_DATA <= tx_holding_reg_ff;
        serial_port_pkg::ADDR_RX_HOLDING: RD_DATA <= rx_holding_reg_ff;
        serial_port_pkg::ADDR_FLAGS: RD_DATA <= {tx_empty_flag_ff, rx_full_flag_ff, overrun_flag_ff,
                                                  framing_fault_flag_ff, parity_fault_flag_ff,
                                                  tx_done_flag_ff, 2'h0};
        serial_port_pkg::ADDR_EXT_MODE: RD_DATA <= ext_mode_reg_ff;
        serial_port_pkg::ADDR_PORT: RD_DATA <= {6'h00, port_reg_ff};
        default: RD_DATA <= 8'h00;
      endcase
    end else begin
      RD_DATA <= 8'h00;
    end
  end

  // ==========================================================
  // sampling clock: internal divider or external pin
  logic ext_clk;
  logic half_sample;
  logic [3:0] sub_last;
  logic [DIV_W-1:0] div_cnt_ff;
  logic sck_s1_ff;
  logic sck_s2_ff;
  logic sck_s3_ff;
  logic tick;
  logic [3:0] phase_ff;

  assign ext_clk = control_reg_ff[serial_port_pkg::CT_CLK_SRC_HI];
  assign half_sample = ext_clk && ext_mode_reg_ff[serial_port_pkg::EM_HALF_SAMPLE];
  assign sub_last = half_sample ? serial_port_pkg::SUB_LAST_X8 : serial_port_pkg::SUB_LAST_X16;
  assign tick = ext_clk ? (sck_s2_ff && !sck_s3_ff) : (div_cnt_ff == rate_div_ff);

  // two-stage synchroniser plus edge stage for the clock pin
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      sck_s1_ff <= 1'b0;
      sck_s2_ff <= 1'b0;
      sck_s3_ff <= 1'b0;
    end else begin
      sck_s1_ff <= SCK_IN;
      sck_s2_ff <= sck_s1_ff;
      sck_s3_ff <= sck_s2_ff;
    end
  end

  // internal divider, one tick per sixteenth of a bit
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      div_cnt_ff <= '0;
    end else if (div_cnt_ff == rate_div_ff) begin
      div_cnt_ff <= '0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 1'b1;
    end
  end

  // phase within a bit, drives the bit-rate clock output
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      phase_ff <= 4'h0;
    end else if (tick) begin
      phase_ff <= phase_ff + 4'h1;
    end
  end

  // clock pin direction by mode
  always_comb begin
    SCK_OE = 1'b0;
    if (cfg.sync_mode_select) begin
      SCK_OE = !ext_clk;
    end else if (!ext_clk && control_reg_ff[serial_port_pkg::CT_CLK_SRC_LO]) begin
      SCK_OE = 1'b1;
    end
  end
  assign SCK_OUT = cfg.sync_mode_select ? 1'b1 : !phase_ff[3];

  // ==========================================================
  // transmitter
  serial_port_pkg::tx_state_type tx_state_ff;
  logic [3:0] tx_sub_ff;
  logic [3:0] tx_pos_ff;
  logic [11:0] tx_frame_ff;
  logic [11:0] tx_next_ff;
  logic tx_pend_ff;
  logic tx_bit_end;
  logic tx_load;
  logic tx_fetch;
  logic tx_finish;

  assign tx_bit_end = tick && (tx_sub_ff == sub_last);
  assign tx_load = (tx_state_ff == serial_port_pkg::TX_IDLE) && !tx_empty_flag_ff;
  // decision taken as the first stop bit begins
  assign tx_fetch = (tx_state_ff == serial_port_pkg::TX_SEND) && tx_bit_end &&
                    (tx_pos_ff + 4'h1 == stop_index(cfg)) && !tx_empty_flag_ff;
  assign tx_finish = (tx_state_ff == serial_port_pkg::TX_SEND) && tx_bit_end &&
                     (tx_pos_ff + 4'h1 == stop_index(cfg)) && tx_empty_flag_ff;

  // frame sequencing
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      tx_state_ff <= serial_port_pkg::TX_OFF;
      tx_sub_ff <= 4'h0;
      tx_pos_ff <= 4'h0;
      tx_frame_ff <= 12'hfff;
      tx_next_ff <= 12'hfff;
      tx_pend_ff <= 1'b0;
    end else if (!tx_on) begin
      tx_state_ff <= serial_port_pkg::TX_OFF;
      tx_pend_ff <= 1'b0;
      tx_frame_ff <= 12'hfff;
    end else begin
      if (tick) begin
        tx_sub_ff <= (tx_sub_ff == sub_last) ? 4'h0 : tx_sub_ff + 4'h1;
      end
      if (tx_fetch) begin
        tx_next_ff <= build_frame(cfg, tx_holding_reg_ff);
        tx_pend_ff <= 1'b1;
      end
      case (tx_state_ff)
        serial_port_pkg::TX_OFF: begin
          tx_state_ff <= serial_port_pkg::TX_PREAMBLE;
          tx_pos_ff <= 4'h0;
          tx_sub_ff <= 4'h0;
        end
        serial_port_pkg::TX_PREAMBLE: begin
          if (tx_bit_end) begin
            tx_pos_ff <= tx_pos_ff + 4'h1;
            if (tx_pos_ff + 4'h1 == frame_len(cfg)) begin
              tx_state_ff <= serial_port_pkg::TX_IDLE;
            end
          end
        end
        serial_port_pkg::TX_IDLE: begin
          if (tx_load) begin
            tx_frame_ff <= build_frame(cfg, tx_holding_reg_ff);
            tx_state_ff <= serial_port_pkg::TX_SEND;
            tx_pos_ff <= 4'h0;
            tx_sub_ff <= 4'h0;
          end
        end
        serial_port_pkg::TX_SEND: begin
          if (tx_bit_end) begin
            tx_frame_ff <= {1'b1, tx_frame_ff[11:1]};
            tx_pos_ff <= tx_pos_ff + 4'h1;
            if (tx_pos_ff + 4'h1 == frame_len(cfg)) begin
              tx_pos_ff <= 4'h0;
              if (tx_pend_ff) begin
                tx_frame_ff <= tx_next_ff;
                tx_pend_ff <= 1'b0;
              end else begin
                tx_state_ff <= serial_port_pkg::TX_IDLE;
              end
            end
          end
        end
        default: tx_state_ff <= serial_port_pkg::TX_OFF;
      endcase
    end
  end

  // line output; with tx_on clear the pin follows the port bits
  assign TXD = tx_on ? tx_frame_ff[0] : port_reg_ff[serial_port_pkg::PT_PORT_OUT];
  assign TXD_OE = tx_on || port_reg_ff[serial_port_pkg::PT_PORT_DIR];

  // transmit flags, hardware set wins over clear
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      tx_empty_flag_ff <= 1'b1;
      tx_done_flag_ff <= 1'b1;
    end else begin
      if (!tx_on || tx_load || tx_fetch) begin
        tx_empty_flag_ff <= 1'b1;
      end else if (wr_tx) begin
        tx_empty_flag_ff <= 1'b0;
      end
      if (tx_finish) begin
        tx_done_flag_ff <= 1'b1;
      end else if (wr_tx || (wr_flags && !WR_DATA[serial_port_pkg::FL_TX_DONE])) begin
        tx_done_flag_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // receiver
  serial_port_pkg::rx_state_type rx_state_ff;
  logic rxd_s1_ff;
  logic rxd_s2_ff;
  logic [3:0] rx_sub_ff;
  logic [3:0] rx_pos_ff;
  logic [9:0] rx_shift_reg_ff;
  logic rx_blocked;
  logic rx_done;
  logic [9:0] rx_bits;
  logic [7:0] rx_data;
  logic rx_par_bad;
  logic rx_stop_bad;

  // errors hold reception off until software clears them
  assign rx_blocked = !rx_on || overrun_flag_ff || framing_fault_flag_ff || parity_fault_flag_ff;

  // input synchroniser
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rxd_s1_ff <= 1'b1;
      rxd_s2_ff <= 1'b1;
    end else begin
      rxd_s1_ff <= RXD;
      rxd_s2_ff <= rxd_s1_ff;
    end
  end

  assign rx_done = (rx_state_ff == serial_port_pkg::RX_BITS) && tick && (rx_sub_ff == sub_last) &&
                   (rx_pos_ff == stop_index(cfg) - 4'h1);

  // frame checks on the completed shift contents plus the stop sample
  always_comb begin
    rx_bits = rx_shift_reg_ff;
    rx_bits[rx_pos_ff] = rxd_s2_ff;
    rx_data = cfg.char7 ? {1'b0, rx_bits[6:0]} : rx_bits[7:0];
    rx_par_bad = cfg.parity_en &&
                 ((^rx_data) ^ rx_bits[data_bits(cfg)] ^ cfg.parity_odd_select);
    rx_stop_bad = !rx_bits[stop_index(cfg) - 4'h1];
  end

  // start detection, mid-bit sampling
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rx_state_ff <= serial_port_pkg::RX_IDLE;
      rx_sub_ff <= 4'h0;
      rx_pos_ff <= 4'h0;
      rx_shift_reg_ff <= 10'h000;
    end else if (rx_blocked) begin
      rx_state_ff <= serial_port_pkg::RX_IDLE;
    end else if (tick) begin
      case (rx_state_ff)
        serial_port_pkg::RX_IDLE: begin
          if (!rxd_s2_ff) begin
            rx_state_ff <= serial_port_pkg::RX_START;
            rx_sub_ff <= 4'h0;
          end
        end
        serial_port_pkg::RX_START: begin
          rx_sub_ff <= rx_sub_ff + 4'h1;
          if (rx_sub_ff == {1'b0, sub_last[3:1]}) begin
            rx_sub_ff <= 4'h0;
            rx_pos_ff <= 4'h0;
            rx_state_ff <= rxd_s2_ff ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_BITS;
          end
        end
        serial_port_pkg::RX_BITS: begin
          rx_sub_ff <= rx_sub_ff + 4'h1;
          if (rx_sub_ff == sub_last) begin
            rx_sub_ff <= 4'h0;
            rx_shift_reg_ff <= rx_bits;
            rx_pos_ff <= rx_pos_ff + 4'h1;
            if (rx_done) begin
              rx_state_ff <= serial_port_pkg::RX_IDLE;
            end
          end
        end
        default: rx_state_ff <= serial_port_pkg::RX_IDLE;
      endcase
    end
  end

  // holding register update
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rx_holding_reg_ff <= 8'h00;
    end else if (rx_done && !rx_full_flag_ff) begin
      rx_holding_reg_ff <= rx_data;
    end
  end

  // receive flags; rx_on has no effect on them, set wins over clear
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rx_full_flag_ff <= 1'b0;
      overrun_flag_ff <= 1'b0;
      framing_fault_flag_ff <= 1'b0;
      parity_fault_flag_ff <= 1'b0;
    end else begin
      if (rx_done && !rx_full_flag_ff && !rx_par_bad && !rx_stop_bad) begin
        rx_full_flag_ff <= 1'b1;
      end else if ((rd_rx && overrun_flag_ff) ||
                   (wr_flags && !WR_DATA[serial_port_pkg::FL_RX_FULL])) begin
        rx_full_flag_ff <= 1'b0;
      end
      if (rx_done && rx_full_flag_ff) begin
        overrun_flag_ff <= 1'b1;
      end else if (wr_flags && !WR_DATA[serial_port_pkg::FL_OVERRUN]) begin
        overrun_flag_ff <= 1'b0;
      end
      if (rx_done && rx_stop_bad) begin
        framing_fault_flag_ff <= 1'b1;
      end else if (wr_flags && !WR_DATA[serial_port_pkg::FL_FRAMING]) begin
        framing_fault_flag_ff <= 1'b0;
      end
      if (rx_done && rx_par_bad) begin
        parity_fault_flag_ff <= 1'b1;
      end else if (wr_flags && !WR_DATA[serial_port_pkg::FL_PARITY]) begin
        parity_fault_flag_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // request lines, level while flag and enable are both set; the tx empty line also needs tx_on
  assign TX_EMPTY_IRQ = tx_on && tx_empty_flag_ff && control_reg_ff[serial_port_pkg::CT_TX_EMPTY_IRQ_ON];
  assign TX_DONE_IRQ = tx_done_flag_ff && control_reg_ff[serial_port_pkg::CT_TX_DONE_IRQ_ON];
  assign RX_FULL_IRQ = rx_full_flag_ff && control_reg_ff[serial_port_pkg::CT_RX_IRQ_ON];
  assign RX_FAULT_IRQ = (overrun_flag_ff || framing_fault_flag_ff || parity_fault_flag_ff) &&
                        control_reg_ff[serial_port_pkg::CT_RX_IRQ_ON];

endmodule : async_serial_port_core

//--- testbench/async_serial_port_core_chk.sv
module async_serial_port_core_chk (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic [4:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [7:0] RD_DATA,
  input wire logic RXD,
  input wire logic TXD,
  input wire logic TXD_OE,
  input wire logic SCK_OUT,
  input wire logic SCK_OE,
  input wire logic TX_EMPTY_IRQ,
  input wire logic TX_DONE_IRQ,
  input wire logic RX_FULL_IRQ,
  input wire logic RX_FAULT_IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] clk_sel_ff;
  logic sync_ff;
  logic tx_on_ff;
  logic [7:0] age_ff;
  logic ctl_wr;
  logic async_int;
  logic oe_exp;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  // expected clock pin direction
  assign ctl_wr = WR_STB && ADDR == serial_port_pkg::ADDR_CONTROL;
  assign async_int = !sync_ff && clk_sel_ff == 2'h1;
  assign oe_exp = sync_ff ? !clk_sel_ff[1] : async_int;
  // ==========================================================
  // shadows of control and mode bits
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      clk_sel_ff <= 2'h0;
      tx_on_ff <= 1'b0;
    end else if (ctl_wr) begin
      clk_sel_ff <= WR_DATA[1:0];
      tx_on_ff <= WR_DATA[5];
    end
  end
  // sync mode select shadow
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) sync_ff <= 1'b0;
    else if (WR_STB && ADDR == serial_port_pkg::ADDR_FRAME_MODE) sync_ff <= WR_DATA[7];
  end
  // cycles since tx_on, saturating
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) age_ff <= 8'hff;
    else if (ctl_wr && WR_DATA[5] && !tx_on_ff) age_ff <= 8'h00;
    else if (age_ff != 8'hff) age_ff <= age_ff + 8'h01;
  end
  // ==========================================================
  // properties
  sequence s_half_high;
    SCK_OUT [*8] ##1 !SCK_OUT;
  endsequence
  property p_sck_oe;
    !$past(WR_STB) |-> SCK_OE == oe_exp;
  endproperty
  a_sck_oe: assert property (p_sck_oe) else $error("clock pin direction wrong");
  property p_sck_wave;
    $rose(SCK_OUT) && async_int && !$past(WR_STB) |-> s_half_high;
  endproperty
  a_sck_wave: assert property (p_sck_wave) else $error("clock out not at bit rate");
  property p_preamble;
    tx_on_ff && age_ff != 8'h00 && age_ff < 8'h98 |-> TXD;
  endproperty
  a_preamble: assert property (p_preamble) else $error("line not idle after enable");
  property p_hold_wr;
    WR_STB && ADDR == serial_port_pkg::ADDR_TX_HOLDING |=> !TX_EMPTY_IRQ && !TX_DONE_IRQ;
  endproperty
  a_hold_wr: assert property (p_hold_wr) else $error("holding write kept empty");
  property p_load;
    $rose(TX_EMPTY_IRQ) && !$past(WR_STB) |-> (!TXD) or (##16 !TXD);
  endproperty
  a_load: assert property (p_load) else $error("load without start bit");
  property p_done;
    $rose(TX_DONE_IRQ) && !$past(WR_STB) |-> TXD;
  endproperty
  a_done: assert property (p_done) else $error("done outside stop bit");
  property p_rx_good;
    $rose(RX_FULL_IRQ) && !$past(WR_STB) |-> RXD;
  endproperty
  a_rx_good: assert property (p_rx_good) else $error("full set without stop bit");
  property p_fault_hold;
    RX_FAULT_IRQ && !WR_STB |=> !$rose(RX_FULL_IRQ);
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("received while faulted");
  property p_port_oe;
    WR_STB && ADDR == serial_port_pkg::ADDR_PORT && WR_DATA[1] |=> TXD_OE;
  endproperty
  a_port_oe: assert property (p_port_oe) else $error("pin not driven");
  property p_rd_idle;
    RD_DATA != 8'h00 |-> $past(RD_STB);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
endmodule : async_serial_port_core_chk

bind async_serial_port_core async_serial_port_core_chk i_chk (.*);

//--- testbench/remote_station.sv
module remote_station (
  input wire logic clock,
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT_CLKS = 16;
  logic [7:0] got_q[$];
  logic [7:0] sh;
  // line idles at mark
  initial rxd = 1'b1;
  // ==========================================================
  // send one frame, lsb first
  task send(input logic [7:0] d, input logic pe, input logic pb, input logic sp);
    logic [10:0] f;
    int n;
    f = {sp, pb, d, 1'b0};
    n = pe ? 11 : 10;
    if (!pe) f[9] = sp;
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      rxd <= f[i];
      repeat (BIT_CLKS - 1) @(posedge clock);
    end
    @(posedge clock);
    rxd <= 1'b1;
    repeat (BIT_CLKS) @(posedge clock);
  endtask : send
  // ==========================================================
  // collect 8-bit frames, mid-bit sampling; only a fall from mark counts
  initial forever begin
    wait (txd === 1'b1);
    @(negedge txd);
    repeat (BIT_CLKS / 2) @(posedge clock);
    if (txd === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge clock);
        sh[i] = txd;
      end
      repeat (BIT_CLKS) @(posedge clock);
      if (txd === 1'b1) got_q.push_back(sh);
    end
  end
endmodule : remote_station

//--- testbench/test_async_serial_port_core.sv
module test_async_serial_port_core;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic sck_in = 1'b0;
  logic [7:0] rd_data;
  logic rxd, txd, txd_oe, sck_out, sck_oe, tx_empty_irq, tx_done_irq, rx_full_irq, rx_fault_irq;
  int err_count = 0;
  int n_checks = 0;
  int seed = 35216;
  logic [7:0] v, b, c;
  logic [7:0] exp_q[$];
  localparam logic [4:0] FM = serial_port_pkg::ADDR_FRAME_MODE, CT = serial_port_pkg::ADDR_CONTROL;
  localparam logic [4:0] TH = serial_port_pkg::ADDR_TX_HOLDING, RH = serial_port_pkg::ADDR_RX_HOLDING;
  localparam logic [4:0] FL = serial_port_pkg::ADDR_FLAGS, PT = serial_port_pkg::ADDR_PORT;
  logic [4:0] ra[7] = '{FM, CT, serial_port_pkg::ADDR_RATE_DIV, FL, serial_port_pkg::ADDR_EXT_MODE, PT, 5'h02};
  logic [7:0] rv[7] = '{8'h00, 8'h00, 8'h00, 8'h84, 8'h00, 8'h00, 8'h00};
  // {oe, sync, clk_src_hi, clk_src_lo}, legal only
  logic [3:0] cs[5] = '{4'h0, 4'h9, 4'h2, 4'hc, 4'h6};
  async_serial_port_core #(.DIV_W(8)) i_async_serial_port_core (
    .CLOCK(clock), .RST_B(rst_b), .ADDR(addr), .WR_DATA(wr_data), .WR_STB(wr_stb), .RD_STB(rd_stb),
    .RD_DATA(rd_data), .RXD(rxd), .TXD(txd), .TXD_OE(txd_oe), .SCK_IN(sck_in), .SCK_OUT(sck_out),
    .SCK_OE(sck_oe), .TX_EMPTY_IRQ(tx_empty_irq), .TX_DONE_IRQ(tx_done_irq),
    .RX_FULL_IRQ(rx_full_irq), .RX_FAULT_IRQ(rx_fault_irq));
  remote_station i_remote_station (.clock(clock), .txd(txd), .rxd(rxd));
  // clocks; external one runs through setup
  always #5 clock = ~clock;
  always #35 sck_in = ~sck_in;
  // ==========================================================
  // register bus
  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask : wr
  task rchk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    `CHK("register", e, rd_data & m)
  endtask : rchk
  function automatic logic par(input logic [7:0] d, input logic odd);
    return ^d ^ odd;
  endfunction : par
  task print_verdict;
    $display("errors %0d checks %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    for (int i = 0; i < 7; i++) rchk(ra[i], 8'hff, rv[i]);
    for (int i = 0; i < 5; i++) begin
      wr(FM, {cs[i][2], 7'h00});
      wr(CT, {6'h00, cs[i][1:0]});
      @(posedge clock);
      #1;
      `CHK("sck_oe", cs[i][3], sck_oe)
    end
    wr(FM, 8'h00);
    // first word lands in the preamble, the rest stream back to back
    wr(CT, 8'hf5);
    for (int i = 0; i < 5; i++) begin
      for (int k = 0; k < 400 && tx_empty_irq !== 1'b1; k++) @(posedge clock);
      b = $random(seed);
      exp_q.push_back(b);
      wr(TH, b);
      #1;
    end
    for (int k = 0; k < 1200 && tx_done_irq !== 1'b1; k++) @(posedge clock);
    // done rises as the stop bit starts; the station takes the byte mid stop bit
    repeat (16) @(posedge clock);
    for (int i = 0; i < 5; i++) `CHK("tx byte", exp_q[i], i_remote_station.got_q[i])
    rchk(FL, 8'h84, 8'h84);
    // receive under each parity mode
    for (int m = 0; m < 3; m++) begin
      v = m == 0 ? 8'h00 : {3'h1, m == 2, 4'h0};
      wr(FM, v);
      b = $random(seed);
      i_remote_station.send(b, v[5], par(b, v[4]), 1'b1);
      `CHK("rx_full_irq", 1'b1, rx_full_irq)
      rchk(RH, 8'hff, b);
      rchk(FL, 8'h78, 8'h40);
      wr(FL, 8'h00);
    end
    // parity then framing fault, each then a blocked frame
    for (int m = 0; m < 2; m++) begin
      wr(FM, m == 0 ? 8'h20 : 8'h00);
      b = $random(seed);
      c = $random(seed);
      i_remote_station.send(b, m == 0, ~par(b, 1'b0), m == 0);
      `CHK("rx_fault_irq", 1'b1, rx_fault_irq)
      i_remote_station.send(c, m == 0, par(c, 1'b0), 1'b1);
      rchk(RH, 8'hff, b);
      rchk(FL, 8'h78, m == 0 ? 8'h08 : 8'h10);
      wr(FL, 8'h00);
    end
    // overrun: second word lost, late read clears full
    wr(FM, 8'h00);
    b = $random(seed);
    c = $random(seed);
    i_remote_station.send(b, 1'b0, 1'b0, 1'b1);
    i_remote_station.send(c, 1'b0, 1'b0, 1'b1);
    `CHK("rx_fault_irq", 1'b1, rx_fault_irq)
    rchk(FL, 8'h78, 8'h60);
    rchk(RH, 8'hff, b);
    rchk(FL, 8'h40, 8'h00);
    wr(FL, 8'h00);
    // both directions off, word pending
    b = $random(seed);
    i_remote_station.send(b, 1'b0, 1'b0, 1'b1);
    wr(TH, 8'h55);
    wr(TH, 8'haa);
    wr(CT, 8'h00);
    rchk(FL, 8'hc0, 8'hc0);
    rchk(RH, 8'hff, b);
    // break through the port bits
    wr(PT, 8'h02);
    @(posedge clock);
    #1;
    `CHK("txd", 1'b0, txd)
    `CHK("txd_oe", 1'b1, txd_oe)
    print_verdict();
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    print_verdict();
  end
endmodule : test_async_serial_port_core
